// >>> core/aau_map.svh
`ifndef AAU_MAP_SVH
`define AAU_MAP_SVH

// =====================================================================
// timing figures in their own units
`define AAU_CLK_MHZ        125
`define AAU_REFRESH_US     25
`define AAU_LATENCY_US     60
`define AAU_WAKE_BASE_US   300
`define AAU_AWAKE_US       260
`define AAU_SLEEP_MS       98

// =====================================================================
// derived cycle counts (all figures are whole cycles at 125 MHz)
`define AAU_REFRESH_CYC    (`AAU_REFRESH_US * `AAU_CLK_MHZ)
`define AAU_LATENCY_CYC    (`AAU_LATENCY_US * `AAU_CLK_MHZ)
`define AAU_WAKE_BASE_CYC  (`AAU_WAKE_BASE_US * `AAU_CLK_MHZ)
`define AAU_AWAKE_CYC      (`AAU_AWAKE_US * `AAU_CLK_MHZ)
`define AAU_SLEEP_CYC      (`AAU_SLEEP_MS * 1000 * `AAU_CLK_MHZ)

// =====================================================================
// field positions and widths
`define AAU_ANGLE_W        13
`define AAU_WORD_W         12
`define AAU_EXP_W          3
`define AAU_EXP_MAX        7
`define AAU_OCT_MSB        12
`define AAU_OCT_LSB        10
`define AAU_TURNS_W        12
`define AAU_TURNS_LIMIT    1280
`define AAU_QDEPTH         3

// =====================================================================
// reset values
`define AAU_MODE_HS_RST    1'b0
`define AAU_ANGLE_RST      13'h0000
`define AAU_TURNS_RST      12'h000

`endif

// >>> core/aau_pkg.sv
`include "aau_map.svh"

package aau_pkg;
    typedef logic [`AAU_ANGLE_W-1:0]        aau_angle_t;
    typedef logic [`AAU_EXP_W-1:0]          aau_exp_t;
    typedef logic signed [`AAU_TURNS_W-1:0] aau_turns_t;

    // power / wake sequencing states
    typedef enum logic [2:0] {
        WC_OFF,
        WC_RUN,
        WC_SLEEP,
        WC_WAKE_DLY,
        WC_AWAKE
    } aau_wake_e;
endpackage

// >>> core/aau_sample_if.sv
`timescale 1ns/1ps

// =====================================================================
// raw samples in, averaged results out
interface aau_sample_if;
    import aau_pkg::*;
    logic       smp_valid;
    aau_angle_t smp;
    aau_exp_t   exp;
    logic       restart;
    logic       res_valid;
    aau_angle_t res;

    modport sample_avg_select  (input smp_valid, smp, exp, restart, output res_valid, res);
    modport core (output smp_valid, smp, exp, restart, input res_valid, res);
endinterface

// >>> core/aau_averager.sv
`timescale 1ns/1ps
`include "aau_map.svh"

module aau_averager (
    input  wire logic   i_clk,
    input  wire logic   i_sys_rst,
    aau_sample_if.sample_avg_select   sif
);
    import aau_pkg::*;

    localparam int SW = `AAU_ANGLE_W + `AAU_EXP_MAX;
    localparam int CW = `AAU_EXP_MAX + 1;

    logic [SW-1:0] acc_r;
    logic [SW-1:0] acc_nxt;
    logic [SW-1:0] sum;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    aau_exp_t      exp_r;
    logic          last;
    logic          stale;

    // =================================================================
    // accumulate 2^n samples, divide by shifting
    // limitation: a plain sum blurs a batch that straddles the 0/360 wrap
    always_comb
    begin
        sum     = acc_r + SW'(sif.smp);
        stale   = sif.restart || (sif.exp != exp_r);
        last    = sif.smp_valid && (cnt_r == ((CW'(1) << sif.exp) - CW'(1)));
        acc_nxt = acc_r;
        cnt_nxt = cnt_r;
        if (stale)
        begin
            // a new exponent never mixes with a half-built batch
            acc_nxt = '0;
            cnt_nxt = '0;
        end
        else if (sif.smp_valid)
        begin
            acc_nxt = last ? '0 : sum;
            cnt_nxt = last ? '0 : cnt_r + CW'(1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            acc_r <= '0;
            cnt_r <= '0;
            exp_r <= '0;
        end
        else
        begin
            acc_r <= acc_nxt;
            cnt_r <= cnt_nxt;
            exp_r <= sif.exp;
        end
    end

    // exponent 0 passes every sample straight through
    assign sif.res_valid = last && !stale;
    assign sif.res       = aau_angle_t'(sum >> sif.exp);
endmodule

// >>> core/aau_turns.sv
`timescale 1ns/1ps
`include "aau_map.svh"

module aau_turns (
    input  wire logic            i_clk,
    input  wire logic            i_sys_rst,
    input  wire logic            i_active,
    input  wire logic            i_step_45,
    input  wire logic            i_angle_valid,
    input  wire aau_pkg::aau_angle_t i_angle,
    output var   aau_pkg::aau_turns_t o_turns
);
    import aau_pkg::*;

    localparam aau_turns_t LIM = aau_turns_t'(`AAU_TURNS_LIMIT);

    logic [2:0] oct_r;
    logic [2:0] oct_nxt;
    logic       seen_r;
    logic       seen_nxt;
    aau_turns_t turns_r;
    aau_turns_t turns_nxt;
    logic [2:0] oct;
    logic       fwd;
    logic       bwd;
    logic       hit;

    // =================================================================
    // octant tracking; 180-degree steps count only at octants 0 and 4
    // a jump of two or more octants between results is not counted
    always_comb
    begin
        oct       = i_angle[`AAU_OCT_MSB:`AAU_OCT_LSB];
        fwd       = (oct == oct_r + 3'h1);
        bwd       = (oct == oct_r - 3'h1);
        hit       = i_step_45 || (fwd ? (oct[1:0] == 2'h0) : (oct_r[1:0] == 2'h0));
        oct_nxt   = oct_r;
        seen_nxt  = seen_r;
        turns_nxt = turns_r;
        if (!i_active)
        begin
            seen_nxt = 1'b0;
        end
        else if (i_angle_valid)
        begin
            oct_nxt  = oct;
            seen_nxt = 1'b1;
            if (seen_r && hit && fwd && turns_r != LIM)
            begin
                turns_nxt = turns_r + aau_turns_t'(1);
            end
            else if (seen_r && hit && bwd && turns_r != -LIM)
            begin
                turns_nxt = turns_r - aau_turns_t'(1);
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            oct_r   <= '0;
            seen_r  <= 1'b0;
            turns_r <= `AAU_TURNS_RST;
        end
        else
        begin
            oct_r   <= oct_nxt;
            seen_r  <= seen_nxt;
            turns_r <= turns_nxt;
        end
    end

    assign o_turns = turns_r;
endmodule

// >>> core/aau_top.sv
// How it works
// - angle is offered to the host as a 12-bit word from registers
// - low-speed mode averages samples; high-speed mode bypasses averaging
// - averaging code n takes 2^n samples, refreshing every 25*2^n us
// - code zero in low-speed mode behaves exactly like high-speed mode
// - high-speed mode loads a new output angle every 25 us
// - output register updates 60 us after the magnet sample
// - every measurement word carries the supply-low flag
// - commands ignored until supply rises above up threshold, until below down
// - sleep ends on wake input, host clear, or speed above 100 rpm
// - awake state holds while measured speed exceeds the awake threshold
// - low-speed turns sampling starts 300 us plus 25*2^n us after wake
// - turns counter steps per 45 or 180 degrees, by configuration bit
// - 13-bit angle value means 360*value/2^13 degrees in every mode
// - at power-up registers take defaults and mode comes from nonvolatile bit
// - low-power operation gives no angle readings, only periodic turns checks
`timescale 1ns/1ps
`include "aau_map.svh"

module aau_top #(
    parameter int unsigned REFRESH_CYC   = `AAU_REFRESH_CYC,
    parameter int unsigned LATENCY_CYC   = `AAU_LATENCY_CYC,
    parameter int unsigned WAKE_BASE_CYC = `AAU_WAKE_BASE_CYC,
    parameter int unsigned AWAKE_CYC     = `AAU_AWAKE_CYC,
    parameter int unsigned SLEEP_CYC     = `AAU_SLEEP_CYC,
    parameter int unsigned QDEPTH        = `AAU_QDEPTH
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_speed_mode_select,
    input  wire aau_pkg::aau_exp_t    i_sample_avg_select,
    input  wire logic                 i_turns_step_45,
    input  wire logic                 i_supply_above_up,
    input  wire logic                 i_supply_below_down,
    input  wire logic                 i_wake_pin,
    input  wire logic                 i_speed_above_awake,
    input  wire logic                 i_low_power_en,
    input  wire logic                 i_host_cmd_valid,
    input  wire logic                 i_host_clear_sleep,
    output logic                      o_sample_req,
    input  wire logic                 i_sample_valid,
    input  wire aau_pkg::aau_angle_t  i_sample,
    output var   aau_pkg::aau_angle_t o_angle,
    output logic [`AAU_WORD_W-1:0]    o_angle_word,
    output logic [`AAU_ANGLE_W:0]     o_meas_word,
    output logic                      o_angle_valid,
    output logic                      o_angle_update,
    output logic                      o_cmd_accept,
    output logic                      o_powered,
    output logic                      o_supply_low,
    output logic                      o_high_speed,
    output logic                      o_low_power,
    output logic                      o_tc_active,
    output logic                      o_tc_start,
    output var   aau_pkg::aau_turns_t o_turns
);
    import aau_pkg::*;

    localparam int unsigned DLY_MAX = WAKE_BASE_CYC + (REFRESH_CYC << `AAU_EXP_MAX);
    localparam int unsigned T1      = (SLEEP_CYC > DLY_MAX) ? SLEEP_CYC : DLY_MAX;
    localparam int unsigned TMAX    = (T1 > AWAKE_CYC) ? T1 : AWAKE_CYC;
    localparam int TW = $clog2(TMAX + 1);
    localparam int RW = $clog2(REFRESH_CYC + 1);
    localparam int LW = $clog2(LATENCY_CYC + 1);
    localparam int QW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;

    // =================================================================
    // start-up: capture the nonvolatile mode once after reset release
    logic init_done_r;
    logic init_done_nxt;
    logic mode_hs_r;
    logic mode_hs_nxt;

    always_comb
    begin
        init_done_nxt = 1'b1;
        mode_hs_nxt   = init_done_r ? mode_hs_r : i_speed_mode_select;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            init_done_r <= 1'b0;
            mode_hs_r   <= `AAU_MODE_HS_RST;
        end
        else
        begin
            init_done_r <= init_done_nxt;
            mode_hs_r   <= mode_hs_nxt;
        end
    end

    // =================================================================
    // pin synchronisers: supply comparators and wake comparator
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       sup_up;
    logic       sup_down;
    logic       wake_in;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {i_wake_pin, i_supply_below_down, i_supply_above_up};
            sync2_r <= sync1_r;
        end
    end

    assign sup_up   = sync2_r[0];
    assign sup_down = sync2_r[1];
    assign wake_in  = sync2_r[2];

    // =================================================================
    // supply gating with hysteresis between the two thresholds
    logic powered_r;
    logic powered_nxt;
    logic slow_r;
    logic slow_nxt;

    always_comb
    begin
        powered_nxt = powered_r ? !sup_down : sup_up;
        slow_nxt    = sup_down;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            powered_r <= 1'b0;
            slow_r    <= 1'b0;
        end
        else
        begin
            powered_r <= powered_nxt;
            slow_r    <= slow_nxt;
        end
    end

    // commands before the supply settles are dropped, not queued
    logic host_clear;
    assign o_cmd_accept = i_host_cmd_valid && powered_r && init_done_r;
    assign host_clear   = i_host_clear_sleep && o_cmd_accept;

    // =================================================================
    // power / wake sequencer
    aau_wake_e st_r;
    aau_wake_e st_nxt;
    logic [TW-1:0] tmr_r;
    logic [TW-1:0] tmr_nxt;
    logic [TW-1:0] dly_cyc;
    logic          wake_cause;
    aau_exp_t      eff_exp;

    // high-speed mode forces exponent 0, so code 000 is the same path
    assign eff_exp    = mode_hs_r ? '0 : i_sample_avg_select;
    assign dly_cyc    = TW'(WAKE_BASE_CYC) + (TW'(REFRESH_CYC) << eff_exp);
    assign wake_cause = wake_in || host_clear || i_speed_above_awake;

    always_comb
    begin
        st_nxt  = st_r;
        tmr_nxt = (tmr_r != '0) ? tmr_r - TW'(1) : tmr_r;
        if (!powered_r)
        begin
            st_nxt = WC_OFF;
        end
        else
        begin
            unique case (st_r)
                WC_OFF:
                begin
                    st_nxt = WC_RUN;
                end
                WC_RUN:
                begin
                    if (i_low_power_en)
                    begin
                        st_nxt  = WC_AWAKE;
                        tmr_nxt = TW'(AWAKE_CYC - 1);
                    end
                end
                WC_AWAKE:
                begin
                    if (!i_low_power_en)
                    begin
                        st_nxt = WC_RUN;
                    end
                    else if (i_speed_above_awake)
                    begin
                        tmr_nxt = TW'(AWAKE_CYC - 1);
                    end
                    else if (tmr_r == '0)
                    begin
                        st_nxt  = WC_SLEEP;
                        tmr_nxt = TW'(SLEEP_CYC - 1);
                    end
                end
                WC_SLEEP:
                begin
                    // periodic wake doubles as the turns
                    if (!i_low_power_en)
                    begin
                        st_nxt = WC_RUN;
                    end
                    else if (wake_cause || tmr_r == '0)
                    begin
                        st_nxt  = WC_WAKE_DLY;
                        tmr_nxt = dly_cyc - TW'(1);
                    end
                end
                WC_WAKE_DLY:
                begin
                    if (!i_low_power_en)
                    begin
                        st_nxt = WC_RUN;
                    end
                    else if (tmr_r == '0)
                    begin
                        st_nxt  = WC_AWAKE;
                        tmr_nxt = TW'(AWAKE_CYC - 1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_r  <= WC_OFF;
            tmr_r <= '0;
        end
        else
        begin
            st_r  <= st_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // sampling runs through the wake delay so the first average is full
    logic sampling;
    assign sampling    = (st_r == WC_RUN) || (st_r == WC_AWAKE) || (st_r == WC_WAKE_DLY);
    assign o_low_power = (st_r == WC_SLEEP) || (st_r == WC_AWAKE) || (st_r == WC_WAKE_DLY);
    assign o_tc_active = (st_r == WC_RUN) || (st_r == WC_AWAKE);
    assign o_tc_start  = powered_r && i_low_power_en && (st_r == WC_WAKE_DLY) && (tmr_r == '0);

    // =================================================================
    // 25 us sample pacing
    logic [RW-1:0] ref_r;
    logic [RW-1:0] ref_nxt;

    always_comb
    begin
        ref_nxt = (!sampling || ref_r == RW'(REFRESH_CYC - 1)) ? '0 : ref_r + RW'(1);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ref_r <= '0;
        end
        else
        begin
            ref_r <= ref_nxt;
        end
    end

    assign o_sample_req = sampling && (ref_r == RW'(REFRESH_CYC - 1));

    // =================================================================
    // averaging
    aau_sample_if sif ();

    assign sif.smp_valid = i_sample_valid && sampling;
    assign sif.smp       = i_sample;
    assign sif.exp       = eff_exp;
    assign sif.restart   = !sampling;

    aau_averager u_avg (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .sif       (sif)
    );

    // =================================================================
    // latency line: a result waits out the response time before it shows
    // depth covers 60 us of results arriving at most every 25 us
    logic [QW-1:0]     wp_r;
    logic [QW-1:0]     wp_nxt;
    logic [QDEPTH-1:0] q_exp;
    aau_angle_t        q_dat [QDEPTH];

    assign wp_nxt = !sif.res_valid ? wp_r :
                    (wp_r == QW'(QDEPTH - 1)) ? '0 : wp_r + QW'(1);

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wp_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
        end
    end

    for (genvar g = 0; g < QDEPTH; g++)
    begin : g_q
        logic          vld_r;
        logic          vld_nxt;
        aau_angle_t    dat_r;
        aau_angle_t    dat_nxt;
        logic [LW-1:0] cnt_r;
        logic [LW-1:0] cnt_nxt;

        always_comb
        begin
            vld_nxt = vld_r;
            dat_nxt = dat_r;
            cnt_nxt = cnt_r;
            if (sif.res_valid && wp_r == QW'(g))
            begin
                vld_nxt = 1'b1;
                dat_nxt = sif.res;
                cnt_nxt = LW'(LATENCY_CYC - 1);
            end
            else if (vld_r)
            begin
                vld_nxt = (cnt_r != '0);
                cnt_nxt = (cnt_r != '0) ? cnt_r - LW'(1) : cnt_r;
            end
        end

        always_ff @(posedge i_clk)
        begin
            if (i_sys_rst)
            begin
                vld_r <= 1'b0;
                dat_r <= `AAU_ANGLE_RST;
                cnt_r <= '0;
            end
            else
            begin
                vld_r <= vld_nxt;
                dat_r <= dat_nxt;
                cnt_r <= cnt_nxt;
            end
        end

        assign q_exp[g] = vld_r && (cnt_r == '0);
        assign q_dat[g] = dat_r;
    end

    // =================================================================
    // output register; entries enter on distinct cycles so one expires
    logic       rel;
    aau_angle_t rel_dat;
    aau_angle_t angle_r;
    aau_angle_t angle_nxt;
    logic       aval_r;
    logic       aval_nxt;
    logic       upd_r;
    logic       upd_nxt;

    always_comb
    begin
        rel     = 1'b0;
        rel_dat = '0;
        for (int i = 0; i < QDEPTH; i++)
        begin
            if (q_exp[i])
            begin
                rel     = 1'b1;
                rel_dat = q_dat[i];
            end
        end
        // low power keeps the last reading but flags it as not valid
        // looks at the next state so no pulse leaks into the first low-power cycle
        upd_nxt   = rel && !o_low_power && (st_nxt inside {WC_RUN, WC_OFF});
        angle_nxt = upd_nxt ? rel_dat : angle_r;
        aval_nxt  = (st_nxt inside {WC_RUN, WC_OFF}) && (aval_r || upd_nxt);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            angle_r <= `AAU_ANGLE_RST;
            aval_r  <= 1'b0;
            upd_r   <= 1'b0;
        end
        else
        begin
            angle_r <= angle_nxt;
            aval_r  <= aval_nxt;
            upd_r   <= upd_nxt;
        end
    end

    // =================================================================
    // turns tracking counts released results in run and also while awake in low power, not in the wake delay
    aau_turns u_turns (
        .i_clk         (i_clk),
        .i_sys_rst     (i_sys_rst),
        .i_active      (o_tc_active),
        .i_step_45     (i_turns_step_45),
        .i_angle_valid (rel),
        .i_angle       (rel_dat),
        .o_turns       (o_turns)
    );

    // full 13-bit value keeps one scale in every mode
    assign o_angle        = angle_r;
    assign o_angle_word   = angle_r[`AAU_ANGLE_W-1:1];
    assign o_meas_word    = {slow_r, angle_r};
    assign o_angle_valid  = aval_r;
    assign o_angle_update = upd_r;
    assign o_powered      = powered_r;
    assign o_supply_low   = slow_r;
    assign o_high_speed   = mode_hs_r;
endmodule

// >>> verif/aau_chk.sv
`timescale 1ns/1ps
// =========================================
// port checks for the averaging and update path
module aau_chk (
    input wire logic                i_clk,
    input wire logic                i_sys_rst,
    input wire logic                i_host_cmd_valid,
    input wire logic                i_sample_valid,
    input wire aau_pkg::aau_angle_t i_sample,
    input wire logic                o_sample_req,
    input wire aau_pkg::aau_angle_t o_angle,
    input wire logic [11:0]         o_angle_word,
    input wire logic [13:0]         o_meas_word,
    input wire logic                o_angle_update,
    input wire logic                o_cmd_accept,
    input wire logic                o_powered,
    input wire logic                o_supply_low,
    input wire logic                o_high_speed,
    input wire logic                o_low_power,
    input wire logic                o_tc_active,
    input wire logic                o_tc_start
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    // the word seen by the host is the top twelve bits
    a_word_top_bits: assert property (o_angle_word == o_angle[12:1])
        else $error("angle word not top bits");
    // the flag rides in every measurement word once settled
    a_meas_word_flag: assert property ($stable(o_angle) && $stable(o_supply_low)
        |-> o_meas_word == {o_supply_low, o_angle}) else $error("meas word wrong");
    a_cmd_gate: assert property (o_cmd_accept |-> i_host_cmd_valid && o_powered)
        else $error("command taken while unpowered");
    a_req_spacing: assert property (o_sample_req && !o_low_power
        |=> (!o_sample_req || o_low_power) [*7]) else $error("sample requests too close");
    // a high speed sample lands after the fixed latency
    a_update_latency: assert property (o_high_speed && i_sample_valid && o_tc_active && !o_low_power
        |-> ##21 (o_angle_update || o_low_power || !o_powered)) else $error("update late");
    a_update_value: assert property (o_angle_update && o_high_speed |-> o_angle == $past(i_sample, 21))
        else $error("updated angle not the sample");
    a_tc_start_next: assert property (o_tc_start |=> o_tc_active || !o_powered)
        else $error("turns sampling not active");
    a_lp_no_update: assert property (o_low_power |-> !o_angle_update)
        else $error("update in low power");
endmodule

bind aau_top aau_chk u_chk (.*);

// >>> verif/aau_sample_src.sv
`timescale 1ns/1ps
// =========================================
// converter model answering each sample request
module aau_sample_src #(
    parameter logic [12:0] VAL_A = 13'h100,
    parameter logic [12:0] VAL_B = 13'h203
) (
    input  wire logic           i_clk,
    input  wire logic           i_req,
    input  wire logic           i_slow,
    output logic                o_valid,
    output aau_pkg::aau_angle_t o_sample
);
    logic [3:0] req_d = 4'h0;
    logic       sel   = 1'b0;
    // slow answers come three cycles after prompt ones
    assign o_valid = i_slow ? req_d[3] : req_d[0];
    // outside valid show the inverse of the last value so stale data never matches
    assign o_sample = o_valid ? (sel ? VAL_B : VAL_A) : ~(sel ? VAL_A : VAL_B);
    always_ff @(posedge i_clk)
    begin
        req_d <= {req_d[2:0], i_req};
        if (o_valid)
            sel <= ~sel;
    end
endmodule

// >>> verif/aau_top_bench.sv
`timescale 1ns/1ps
// =========================================
// bench for the averaging and update block
module aau_top_bench;
    import aau_pkg::*;
    localparam logic [12:0] A = 13'h100;
    localparam logic [12:0] B = 13'h203;
    logic       clk = 1'b0, rst = 1'b1, mode = 1'b1, sup_up = 1'b0, sup_dn = 1'b0;
    logic       spd = 1'b0, lpen = 1'b0, cmd = 1'b0, clr = 1'b0, slow = 1'b0, wk = 1'b0, st45 = 1'b0;
    aau_exp_t   sample_avg_select = 3'h0;
    logic       req, sv, upd, acc, pwr, slo, hs, lp, tcs, av, a;
    aau_angle_t smp, ang;
    logic [11:0] wrd, trn;
    logic [13:0] mw;
    int         err_count = 0, n_tests = 0, cyc = 0, n;
    aau_top #(.REFRESH_CYC(8), .LATENCY_CYC(20), .WAKE_BASE_CYC(30), .AWAKE_CYC(40), .SLEEP_CYC(200)) dut (
        .i_clk(clk), .i_sys_rst(rst), .i_speed_mode_select(mode), .i_sample_avg_select(sample_avg_select),
        .i_turns_step_45(st45), .i_supply_above_up(sup_up), .i_supply_below_down(sup_dn),
        .i_wake_pin(wk), .i_speed_above_awake(spd), .i_low_power_en(lpen), .i_host_cmd_valid(cmd),
        .i_host_clear_sleep(clr), .o_sample_req(req), .i_sample_valid(sv), .i_sample(smp),
        .o_angle(ang), .o_angle_word(wrd), .o_meas_word(mw), .o_angle_valid(av), .o_angle_update(upd),
        .o_cmd_accept(acc), .o_powered(pwr), .o_supply_low(slo), .o_high_speed(hs), .o_low_power(lp),
        .o_tc_active(), .o_tc_start(tcs), .o_turns(trn));
    aau_sample_src #(.VAL_A(A), .VAL_B(B)) src (.i_clk(clk), .i_req(req), .i_slow(slow), .o_valid(sv),
        .o_sample(smp));
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_count++;
            test_done();
        end
    end
    // =========================================
    // shared tasks
    task automatic check(input string nm, input logic [13:0] got, input logic [13:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // n counts edges until the flag is seen, bounded
    task automatic wait_for(input bit t);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while ((t ? tcs : upd) !== 1'b1 && n < 3000);
    endtask
    task automatic send_cmd();
        @(posedge clk);
        cmd <= 1'b1;
        clr <= 1'b1;
        #1 a = acc;
        @(posedge clk);
        cmd <= 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // =========================================
    // scenarios
    task automatic t_power();
        send_cmd();
        check("early accept", a, 0);
        sup_up <= 1'b1;
        repeat (8) @(posedge clk);
        check("powered", pwr, 1);
        check("mode", hs, 1);
    endtask
    task automatic t_hs();
        slow <= 1'b1;
        wait_for(0);
        wait_for(0);
        check("hs period", n, 8);
        check("hs angle", (ang === A) || (ang === B), 1);
        check("word", wrd, ang[12:1]);
        check("meas", mw, {slo, ang});
        check("turns", trn, 0);
    endtask
    task automatic t_sleep(input int exp_n, input int how);
        @(posedge clk);
        lpen <= 1'b1;
        repeat (44) @(posedge clk);
        check("low power", lp, 1);
        check("valid in low power", av, 0);
        if (how == 1)
            send_cmd();
        else
        begin
            @(posedge clk);
            spd <= (how == 0);
            wk <= (how == 2);
            @(posedge clk);
            spd <= 1'b0;
            wk <= 1'b0;
            // the pin path waits out its two-stage synchroniser
            repeat (how) @(posedge clk);
            a = acc;
        end
        check("wake accept", a, (how == 1));
        wait_for(1);
        check("wake delay", 14'(n + 1), 14'(exp_n));
        lpen <= 1'b0;
    endtask
    task automatic t_avg();
        mode <= 1'b0;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        for (int k = 0; k < 8; k++)
        begin
            sample_avg_select <= 3'(k);
            wait_for(0);
            wait_for(0);
            wait_for(0);
            check("refresh period", 14'(n), 14'(8 << k));
            check("average", (k == 0) ? (ang === A || ang === B) : (ang === 13'((A + B) >> 1)), 1);
        end
        sample_avg_select <= 3'h3;
    endtask
    task automatic t_supply();
        sup_dn <= 1'b1;
        repeat (6) @(posedge clk);
        check("low flag", slo, 1);
        check("flag in word", mw[13], 1);
        send_cmd();
        check("accept after drop", a, 0);
    endtask
    // =========================================
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_power();
        t_hs();
        t_sleep(38, 1);
        t_sleep(38, 2);
        t_avg();
        t_sleep(94, 0);
        t_supply();
        test_done();
    end
endmodule
